// ===== verilog/ssw_switch.sv
`default_nettype none
// ==========================================================================
// serial port switch control: port choice, status pin, handshake power
module ssw_switch (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // static jumper pins
  input  wire ssw_pkg::ssw_jumper_s          jumper_pin,
  // live control pins
  input  wire ssw_pkg::ssw_ctl_s             ctl_pin,
  // port select terminal, two-way
  output logic                               port_sel_out,
  output logic                               port_sel_oe,
  // port routing and port a supply
  output logic                               port_a_connect,
  output logic                               port_b_connect,
  output logic                               hs_power_en,
  output logic                               port_a_dte,
  // logger data stream in
  input  wire logic                          logger_valid,
  input  wire logic [ssw_pkg::SSW_DATA_W-1:0] logger_data,
  output logic                               logger_ready,
  // port a data out
  output logic                               port_a_valid,
  output logic      [ssw_pkg::SSW_DATA_W-1:0] port_a_data,
  input  wire logic                          port_a_ready,
  // port b data out
  output logic                               port_b_valid,
  output logic      [ssw_pkg::SSW_DATA_W-1:0] port_b_data,
  input  wire logic                          port_b_ready,
  // register port
  input  wire logic [ssw_pkg::SSW_ADDR_W-1:0] reg_addr,
  input  wire logic [ssw_pkg::SSW_REG_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ssw_pkg::SSW_REG_W-1:0]  reg_rdata
);
  import ssw_pkg::*;

  localparam int JW = $bits(ssw_jumper_s);
  localparam int CTW = $bits(ssw_ctl_s);
  localparam int LW = $clog2(SSW_FIFO_DEPTH+1);

  // ========================================================================
  // pin synchronisation
  ssw_jumper_s           jmp;
  ssw_ctl_s              ctl;
  logic [JW+CTW-1:0]     pins_s;

  ssw_sync #(
    .WIDTH (JW+CTW)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d_in    ({jumper_pin, ctl_pin}),
    .d_out   (pins_s)
  );

  // split the synchronised bundle back into its groups
  assign jmp = ssw_jumper_s'(pins_s[JW+CTW-1:CTW]);
  assign ctl = ssw_ctl_s'(pins_s[CTW-1:0]);

  // ========================================================================
  // port selection
  ssw_state_e state;
  ssw_state_e next_state;
  logic       sel_b;
  logic       next_sel_b;
  logic       revert_sel_b;
  logic       auto_sel_b;

  // fallback choice when a session ends
  assign revert_sel_b = jmp.revert_on_idle ? jmp.revert_target_b
                                           : sel_b;
  // idle choice follows activity, port a first
  assign auto_sel_b   = ctl.req_a ? 1'b0 : (ctl.req_b ? 1'b1 : sel_b);

  // next state: manual wins, then session held by modem enable
  always_comb begin
    case (state)
      SSW_ST_IDLE,
      SSW_ST_SESSION,
      SSW_ST_MANUAL: begin
        if (ctl.manual_mode) begin
          next_state = SSW_ST_MANUAL;
        end else if (ctl.modem_enable) begin
          next_state = SSW_ST_SESSION;
        end else begin
          next_state = SSW_ST_IDLE;
        end
      end
      default: next_state = SSW_ST_IDLE;
    endcase
  end

  // next port; one bit, so one port is always connected
  always_comb begin
    case (state)
      SSW_ST_SESSION: begin
        if (ctl.manual_mode) begin
          next_sel_b = ctl.port_select;
        end else if (ctl.modem_enable) begin
          next_sel_b = sel_b;
        end else begin
          next_sel_b = revert_sel_b;
        end
      end
      SSW_ST_IDLE,
      SSW_ST_MANUAL: begin
        if (ctl.manual_mode) begin
          next_sel_b = ctl.port_select;
        end else if (ctl.modem_enable) begin
          next_sel_b = sel_b;
        end else begin
          next_sel_b = auto_sel_b;
        end
      end
      default: next_sel_b = sel_b;
    endcase
  end

  // selection registers and one-hot connect outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state          <= SSW_ST_IDLE;
      sel_b          <= SSW_SEL_B_RST;
      port_b_connect <= SSW_SEL_B_RST;
      port_a_connect <= ~SSW_SEL_B_RST;
    end else begin
      state          <= next_state;
      sel_b          <= next_sel_b;
      port_b_connect <= next_sel_b;
      port_a_connect <= ~next_sel_b;
    end
  end

  // ========================================================================
  // status terminal, handshake power and port a role
  logic next_sel_oe;
  logic next_power;
  logic power_want;

  // drive only in auto mode with the status jumper fitted
  assign next_sel_oe = jmp.port_status_output & ~ctl.manual_mode;
  // wanted power: hold, modem enable, or sync enable if allowed
  assign power_want  = jmp.hs_power_hold | ctl.modem_enable
                     | (jmp.hs_power_sync & ctl.sync_device_enable);
  // master enable and isolation gate everything
  assign next_power  = power_want & jmp.hs_power & ~jmp.isolated;

  // registered pin outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_sel_oe  <= 1'b0;
      port_sel_out <= 1'b0;
      hs_power_en  <= 1'b0;
      port_a_dte   <= 1'b0;
    end else begin
      port_sel_oe  <= next_sel_oe;
      port_sel_out <= next_sel_b;
      hs_power_en  <= next_power;
      port_a_dte   <= jmp.role_dte;
    end
  end

  // ========================================================================
  // data path: fifo, then an output stage toward the chosen port
  logic                  path_en;
  logic                  fifo_valid;
  logic [SSW_DATA_W-1:0] fifo_data;
  logic [LW-1:0]         fifo_level;
  logic                  stage_free;
  logic                  pop;
  logic                  drop;
  logic                  load;
  logic [7:0]            drop_cnt;

  ssw_fifo #(
    .WIDTH (SSW_DATA_W),
    .DEPTH (SSW_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (logger_valid),
    .in_data   (logger_data),
    .in_ready  (logger_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (stage_free & path_en),
    .level     (fifo_level)
  );

  // stage empties when empty or its word is taken
  assign stage_free = (~port_a_valid & ~port_b_valid)
                    | (port_a_valid & port_a_ready)
                    | (port_b_valid & port_b_ready);
  assign pop  = fifo_valid & stage_free & path_en;
  // words for port a vanish while sync data is blocked
  assign drop = ~sel_b & jmp.sync_data_block
              & ctl.sync_device_enable;
  assign load = pop & ~drop;

  // output stage toward the selected port
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_a_valid <= 1'b0;
      port_b_valid <= 1'b0;
      port_a_data  <= '0;
      port_b_data  <= '0;
    end else begin
      if (stage_free) begin
        port_a_valid <= load & ~sel_b;
        port_b_valid <= load & sel_b;
      end
      if (load & ~sel_b) begin
        port_a_data <= fifo_data;
      end
      if (load & sel_b) begin
        port_b_data <= fifo_data;
      end
    end
  end

  // ========================================================================
  // register port
  logic [SSW_REG_W-1:0] ctrl_word;
  logic [SSW_REG_W-1:0] status_word;
  logic [SSW_REG_W-1:0] rd_mux;
  logic                 ctrl_hit;

  assign ctrl_hit    = reg_wr & (reg_addr == SSW_ADDR_CTRL);
  assign ctrl_word   = {31'h00000000, path_en};
  assign status_word = {8'h00, drop_cnt, 4'h0, LW'(fifo_level), 3'h0,
                        port_sel_oe, hs_power_en,
                        (state == SSW_ST_SESSION),
                        (state == SSW_ST_MANUAL), sel_b};
  assign rd_mux = (reg_addr == SSW_ADDR_CTRL)    ? ctrl_word   :
                  (reg_addr == SSW_ADDR_STATUS)  ? status_word :
                  (reg_addr == SSW_ADDR_JUMPERS) ? {23'h000000, jmp} :
                                                   32'h00000000;

  // control write, drop counter, read data for one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      path_en   <= SSW_CTRL_PATH_EN_RST;
      drop_cnt  <= 8'h00;
      reg_rdata <= '0;
    end else begin
      if (ctrl_hit) begin
        path_en <= reg_wdata[SSW_CTRL_PATH_EN_BIT];
      end
      if (pop & drop) begin
        drop_cnt <= drop_cnt + 8'h01;
      end
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ========================================================================
  // checks
  property p_one_port;
    @(posedge clk_sys) disable iff (rst)
    port_a_connect != port_b_connect;
  endproperty
  a_one_port: assert property (p_one_port)
    else $error("both or neither port connected");

  property p_status_drive;
    @(posedge clk_sys) disable iff (rst)
    (jmp.port_status_output && !ctl.manual_mode) |=>
      port_sel_oe && (port_sel_out == port_b_connect);
  endproperty
  a_status_drive: assert property (p_status_drive)
    else $error("status terminal not showing selected port");

  property p_status_release;
    @(posedge clk_sys) disable iff (rst)
    (!jmp.port_status_output || ctl.manual_mode) |=> !port_sel_oe;
  endproperty
  a_status_release: assert property (p_status_release)
    else $error("status terminal driven when it must be an input");

  property p_revert;
    @(posedge clk_sys) disable iff (rst)
    (state == SSW_ST_SESSION && !ctl.modem_enable && !ctl.manual_mode
     && jmp.revert_on_idle)
      |=> port_b_connect == $past(jmp.revert_target_b);
  endproperty
  a_revert: assert property (p_revert)
    else $error("no fallback to target port after session");

  property p_keep_last;
    @(posedge clk_sys) disable iff (rst)
    (state == SSW_ST_SESSION && !ctl.modem_enable && !ctl.manual_mode
     && !jmp.revert_on_idle) |=> $stable(port_b_connect);
  endproperty
  a_keep_last: assert property (p_keep_last)
    else $error("port changed at session end without revert");

  property p_block_a;
    @(posedge clk_sys) disable iff (rst)
    (pop && drop) |=> !$rose(port_a_valid)
      && drop_cnt == $past(drop_cnt) + 8'h01;
  endproperty
  a_block_a: assert property (p_block_a)
    else $error("blocked sync data reached port a");

  property p_power_hold;
    @(posedge clk_sys) disable iff (rst)
    (jmp.hs_power_hold && jmp.hs_power && !jmp.isolated) |=> hs_power_en;
  endproperty
  a_power_hold: assert property (p_power_hold)
    else $error("held handshake power dropped");

  property p_power_off;
    @(posedge clk_sys) disable iff (rst)
    (!jmp.hs_power_hold && !ctl.modem_enable
     && !(jmp.hs_power_sync && ctl.sync_device_enable)) |=> !hs_power_en;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("handshake power on without a cause");

  property p_power_gate;
    @(posedge clk_sys) disable iff (rst)
    (!jmp.hs_power || jmp.isolated) |=> !hs_power_en;
  endproperty
  a_power_gate: assert property (p_power_gate)
    else $error("handshake power on while disabled or isolated");

  property p_role;
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> port_a_dte == $past(jmp.role_dte);
  endproperty
  a_role: assert property (p_role)
    else $error("port a role does not follow its jumper");

  property p_session_hold;
    @(posedge clk_sys) disable iff (rst)
    (state == SSW_ST_SESSION && ctl.modem_enable && !ctl.manual_mode)
      |=> $stable(port_b_connect);
  endproperty
  a_session_hold: assert property (p_session_hold)
    else $error("port switched during a session");

  property p_manual;
    @(posedge clk_sys) disable iff (rst)
    ctl.manual_mode |=> port_b_connect == $past(ctl.port_select);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual choice not followed");

  property p_pin_sync;
    @(posedge clk_sys) disable iff (rst)
    (!$past(rst) && !$past(rst, 2)) |->
      pins_s == $past({jumper_pin, ctl_pin}, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pins not delayed by two flip-flops");

endmodule
`default_nettype wire

// ===== verilog/ssw_pkg.sv
`default_nettype none
// ==========================================================================
// shared constants and types of the serial port switch
package ssw_pkg;

  // ========================================================================
  // widths and depths
  localparam int SSW_DATA_W      = 8;
  localparam int SSW_FIFO_DEPTH  = 8;
  localparam int SSW_SYNC_STAGES = 2;
  localparam int SSW_ADDR_W      = 4;
  localparam int SSW_REG_W       = 32;

  // ========================================================================
  // register offsets (byte addresses)
  localparam logic [SSW_ADDR_W-1:0] SSW_ADDR_CTRL    = 4'h0;
  localparam logic [SSW_ADDR_W-1:0] SSW_ADDR_STATUS  = 4'h4;
  localparam logic [SSW_ADDR_W-1:0] SSW_ADDR_JUMPERS = 4'h8;

  // ========================================================================
  // control register fields and reset values
  localparam int   SSW_CTRL_PATH_EN_BIT = 0;
  localparam logic SSW_CTRL_PATH_EN_RST = 1'h1;
  localparam logic SSW_SEL_B_RST        = 1'h0;   // port a after reset

  // ========================================================================
  // static jumper options, fitted = 1
  typedef struct packed {
    logic port_status_output;   // terminal shows port in auto mode
    logic revert_on_idle;       // fall back when session ends
    logic revert_target_b;      // fall back to port b, else port a
    logic sync_data_block;      // mute port a during sync data
    logic hs_power;             // handshake power allowed at all
    logic hs_power_hold;        // handshake power on if allowed and not isolated
    logic hs_power_sync;        // sync enable also powers handshake
    logic role_dte;             // port a acts as dte, else dce
    logic isolated;             // port a optically isolated
  } ssw_jumper_s;

  // ========================================================================
  // live control pins from the datalogger and terminals
  typedef struct packed {
    logic modem_enable;         // session in progress
    logic sync_device_enable;   // synchronous data running
    logic manual_mode;          // manual mode terminal
    logic port_select;          // manual choice, high = port b
    logic req_a;                // activity request on port a
    logic req_b;                // activity request on port b
  } ssw_ctl_s;

  // ========================================================================
  // selection state
  typedef enum logic [1:0] {
    SSW_ST_IDLE,
    SSW_ST_SESSION,
    SSW_ST_MANUAL
  } ssw_state_e;

endpackage
`default_nettype wire

// ===== verilog/ssw_sync.sv
`default_nettype none
// ==========================================================================
// two flip-flop synchroniser for a bundle of pin levels
module ssw_sync #(
  parameter int WIDTH  = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // pin side and synchronised side
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] d_out
);
  import ssw_pkg::*;

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta  <= '0;
      d_out <= '0;
    end else begin
      meta  <= d_in;
      d_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ssw_fifo.sv
`default_nettype none
// ==========================================================================
// small synchronous fifo with valid/ready on both sides
module ssw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // fill side
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  // drain side
  output logic                            out_valid,
  output logic      [WIDTH-1:0]           out_data,
  input  wire logic                       out_ready,
  // fill level
  output logic      [$clog2(DEPTH+1)-1:0] level
);
  import ssw_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH-1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // handshakes and occupancy
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];
  assign level      = count;

  // storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
      end
      count    <= next_count;
      in_ready <= (next_count != FULL);
    end
  end
endmodule
`default_nettype wire

// ===== test/ssw_far.sv
`default_nettype none
// ==========================================================================
// far side: select terminal pull and the two port receivers
module ssw_far (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // select terminal
  input  wire logic       sel_out,
  input  wire logic       sel_oe,
  input  wire logic       pull_high,
  output logic            sel_wire,
  // receivers
  input  wire logic       a_valid,
  input  wire logic [7:0] a_data,
  input  wire logic       b_valid,
  input  wire logic [7:0] b_data,
  input  wire logic       slow,
  output logic            rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_a[$];
  logic [7:0] got_b[$];
  // terminal level: switch drives it, else the outside pulls it
  assign sel_wire = sel_oe ? sel_out : pull_high;
  // receivers take a word where valid meets ready; slow halves the rate
  always @(posedge clk_sys) begin
    if (rst) begin
      rdy <= 1'b0;
    end else begin
      rdy <= !slow || !rdy;
      if (a_valid && rdy) got_a.push_back(a_data);
      if (b_valid && rdy) got_b.push_back(b_data);
    end
  end
endmodule
`default_nettype wire

// ===== test/ssw_switch_tb.sv
`default_nettype none
// ==========================================================================
// self-checking bench of the serial port switch
module ssw_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssw_pkg::*;
  logic        clk_sys, rst, sel_wire, sel_out, sel_oe, a_con, b_con;
  logic        pwr, dte, lv, lr, av, bv, rdy, slow, pull_high;
  logic        reg_wr, reg_rd;
  logic [7:0]  ld, ad, bd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  ssw_jumper_s jp;
  ssw_ctl_s    ctl;
  int          n_errors, cmp_count, i;
  bit          ok;

  ssw_switch uut (.clk_sys(clk_sys), .rst(rst), .jumper_pin(jp),
    .ctl_pin({ctl[5:3], sel_wire, ctl[1:0]}), .port_sel_out(sel_out),
    .port_sel_oe(sel_oe), .port_a_connect(a_con), .port_b_connect(b_con),
    .hs_power_en(pwr), .port_a_dte(dte), .logger_valid(lv),
    .logger_data(ld), .logger_ready(lr), .port_a_valid(av),
    .port_a_data(ad), .port_a_ready(rdy), .port_b_valid(bv),
    .port_b_data(bd), .port_b_ready(rdy), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ssw_far far (.clk_sys(clk_sys), .rst(rst), .sel_out(sel_out),
    .sel_oe(sel_oe), .pull_high(pull_high), .sel_wire(sel_wire),
    .a_valid(av), .a_data(ad), .b_valid(bv), .b_data(bd), .slow(slow),
    .rdy(rdy));

  // ========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic pins(input logic me, ra, rb);
    @(posedge clk_sys);
    ctl.modem_enable <= me;
    ctl.req_a        <= ra;
    ctl.req_b        <= rb;
    settle();
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic push(input logic [7:0] v, output bit taken);
    taken = 0;
    @(posedge clk_sys);
    lv <= 1'b1;
    ld <= v;
    for (int k = 0; k < 4 && !taken; k++) begin
      @(negedge clk_sys) taken = (lr === 1'b1);
      @(posedge clk_sys);
    end
    lv <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset;
    chk({a_con, b_con, sel_oe, pwr, dte, lr}, 6'h21, "reset pins");
    rd(SSW_ADDR_CTRL, d);
    chk(d, 32'h1, "ctrl reset");
    rd(4'hC, d);
    chk(d, 32'h0, "unmapped read");
  endtask
  task automatic t_power;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      {jp.hs_power, jp.hs_power_hold, jp.hs_power_sync} <= i[2:0];
      jp.isolated <= i[3];
      jp.role_dte <= i[5];
      ctl.modem_enable <= i[4];
      ctl.sync_device_enable <= i[5];
      settle();
      chk(pwr, i[2] & ~i[3] & (i[1] | i[4] | (i[0] & i[5])), "pwr");
      chk(dte, i[5], "role");
      chk(a_con ^ b_con, 1'b1, "one port");
    end
    jp <= '0;
    ctl <= '0;
    @(posedge clk_sys);
  endtask
  task automatic t_session;
    jp.revert_on_idle <= 1'b1;
    pins(0, 0, 1);
    pins(1, 1, 0); // session is held high by the logger
    chk(b_con, 1'b1, "session hold");
    pins(0, 0, 0);
    chk(a_con, 1'b1, "revert a");
    jp.revert_target_b <= 1'b1;
    pins(1, 0, 0);
    pins(0, 0, 0);
    chk(b_con, 1'b1, "revert b");
    jp.revert_on_idle <= 1'b0;
    pins(0, 1, 0);
    pins(1, 0, 0);
    pins(0, 0, 0);
    chk(a_con, 1'b1, "keep last");
  endtask
  task automatic t_manual;
    jp.port_status_output <= 1'b1;
    pins(0, 0, 1);
    chk({sel_oe, sel_out}, 2'h3, "status b");
    pins(0, 1, 0);
    chk({sel_oe, sel_out}, 2'h2, "status a");
    ctl.manual_mode <= 1'b1;
    pull_high <= 1'b1;
    // terminal is released first, then the pulled level is synchronised
    settle();
    settle();
    chk({sel_oe, b_con}, 2'h1, "manual b");
    pull_high <= 1'b0;
    pins(0, 0, 1);
    chk(a_con, 1'b1, "manual a");
    ctl.manual_mode <= 1'b0;
    jp.port_status_output <= 1'b0;
    settle();
  endtask
  task automatic t_data;
    pins(0, 1, 0);
    push(8'h5A, ok);
    push(8'hA5, ok);
    repeat (10) @(posedge clk_sys);
    chk(far.got_a.size(), 2, "a count");
    chk({far.got_a[0], far.got_a[1]}, 16'h5AA5, "a order");
    jp.sync_data_block <= 1'b1;
    ctl.sync_device_enable <= 1'b1;
    settle();
    push(8'h33, ok);
    repeat (10) @(posedge clk_sys);
    chk(far.got_a.size(), 2, "blocked");
    rd(SSW_ADDR_STATUS, d);
    chk(d[23:16], 8'h01, "drop count");
    jp.sync_data_block <= 1'b0;
    settle();
    push(8'h44, ok);
    repeat (10) @(posedge clk_sys);
    chk(far.got_a[$], 8'h44, "pass through");
    ctl.sync_device_enable <= 1'b0;
    wr(SSW_ADDR_CTRL, 32'h0);
    slow <= 1'b1;
    pins(0, 0, 1);
    for (i = 0; i < 9; i++) begin
      push(i[7:0], ok);
      chk(ok, i < 8, "fill");
    end
    rd(SSW_ADDR_STATUS, d);
    chk(d[11:8], 4'h8, "level full");
    wr(SSW_ADDR_CTRL, 32'h1);
    for (i = 0; i < 60 && far.got_b.size() < 8; i++) @(posedge clk_sys);
    chk(far.got_b.size(), 8, "drained");
    foreach (far.got_b[k]) chk(far.got_b[k], k, "b order");
  endtask

  // ========================================================================
  // clock and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, lv, reg_wr, reg_rd, slow, pull_high} = 6'h20;
    {ld, reg_addr, reg_wdata, jp, ctl} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_power();
    t_session();
    t_manual();
    t_data();
    report_and_stop();
  end
endmodule
`default_nettype wire
